// ---- verilog/reset_pkg.sv ----
package reset_pkg;

    // ==================================================================
    // Timing
    localparam int unsigned CLK_PERIOD_NS = 100;
    // Longest extensions round down, least pulse width rounds up
    localparam int unsigned POR_EXT_NS = 30000;
    localparam int unsigned POR_EXT_CYC = POR_EXT_NS / CLK_PERIOD_NS;
    localparam int unsigned BOR_EXT_NS = 100000;
    localparam int unsigned BOR_EXT_CYC = BOR_EXT_NS / CLK_PERIOD_NS;
    localparam int unsigned PIN_MIN_NS = 2000;
    localparam int unsigned PIN_MIN_CYC = (PIN_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned MS_NS = 1000000;
    localparam int unsigned MS_CYC = MS_NS / CLK_PERIOD_NS;
    localparam int unsigned CNT_W = 32;

    // ==================================================================
    // Register map (word index on the plain port)
    localparam int unsigned ADDR_W = 4;
    localparam int unsigned DATA_W = 16;
    localparam logic [3:0] OFS_CAUSE = 4'h0;
    localparam logic [3:0] OFS_IRQ_STATUS = 4'h1;
    localparam logic [3:0] OFS_IRQ_CLEAR = 4'h2;
    localparam logic [3:0] OFS_IRQ_ENABLE = 4'h3;
    localparam logic [3:0] OFS_POWER_CONFIG = 4'h4;

    // ==================================================================
    // Cause flag positions
    localparam int unsigned BIT_POR = 0;
    localparam int unsigned BIT_BOR = 1;
    localparam int unsigned BIT_IDLE = 2;
    localparam int unsigned BIT_SLEEP = 3;
    localparam int unsigned BIT_WDT = 4;
    localparam int unsigned BIT_INSTR = 6;
    localparam int unsigned BIT_PIN = 7;
    localparam int unsigned BIT_MISMATCH = 9;
    localparam int unsigned BIT_ILLEGAL = 14;
    localparam int unsigned BIT_TRAP = 15;
    localparam logic [15:0] FLAG_MASK = 16'hc2df;
    localparam logic [15:0] CAUSE_RESET = 16'h0003;
    localparam logic [15:0] POR_KEEP = 16'h4000;
    localparam logic [15:0] BOR_KEEP = 16'h4081;

    // ==================================================================
    // Power-up delay select and decode constants
    localparam int unsigned PDS_W = 3;
    localparam logic [2:0] PDS_RESET = 3'h3;
    localparam logic [7:0] ILLEGAL_UPPER = 8'h3f;
    localparam logic [3:0] HARD_TRAP_LO = 4'hd;
    localparam logic [3:0] HARD_TRAP_HI = 4'hf;
    localparam logic [3:0] W_STACK = 4'hf;
    localparam logic [23:0] RESTRICT_LO_DEF = 24'h000200;
    localparam logic [23:0] RESTRICT_HI_DEF = 24'h0003ff;

    typedef enum logic [2:0] {
        PW_POR_LOW,
        PW_POR_EXT,
        PW_BOR_LOW,
        PW_BOR_EXT,
        PW_RUN
    } power_state_t;

    // Eight settings from 0 ms up to 128 ms
    function automatic logic [7:0] powerup_ms(input logic [2:0] sel);
        logic [7:0] ms;
        ms = 8'h00;
        unique case (sel)
            3'h0: ms = 8'h00;
            3'h1: ms = 8'h02;
            3'h2: ms = 8'h04;
            3'h3: ms = 8'h08;
            3'h4: ms = 8'h10;
            3'h5: ms = 8'h20;
            3'h6: ms = 8'h40;
            3'h7: ms = 8'h80;
        endcase
        return ms;
    endfunction : powerup_ms

endpackage : reset_pkg

// ---- verilog/system_reset_cause_logic.sv ----
// Contract
// - Hold reset through power-on then brown-out extension and delay, flag bit0
// - Brown-out holds reset until extension, flag bit1
// - Three-bit select picks power-up delay 0-128 ms
// - Each rise above brown-out restarts full delay
// - Filtered low pin resets, flag bit7
// - Reset instruction resets one cycle, flag bit6
// - Watchdog timeout resets, keeps clock, flag bit4
// - Watchdog timeout in sleep/idle only wakes
// - Lower hard trap during trap: conflict reset, bit15
// - Pin-select shadow mismatch resets, flag bit9
// - Illegal conditions share flag bit14
// - Upper byte 3Fh is illegal opcode reset
// - Reset clears W0-W14; uninitialised pointer resets
// - Reload into restricted segment is security reset
// - Watchdog flag cleared by save, clear, POR, BOR
// - Software sets/clears flags; POR/BOR clear selectively
// - Cold reset reselects fuse clock; warm keeps current
module system_reset_cause_logic #(
    parameter int unsigned MS_CYCLES = reset_pkg::MS_CYC,
    parameter logic [23:0] RESTRICT_LO = reset_pkg::RESTRICT_LO_DEF,
    parameter logic [23:0] RESTRICT_HI = reset_pkg::RESTRICT_HI_DEF
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rstn,
    // Supply supervisors and reset pin (asynchronous)
    input wire logic supply_above_poweron_threshold,
    input wire logic supply_above_brownout_threshold,
    input wire logic external_reset_pin_n,
    // CPU core events
    input wire logic reset_instr,
    input wire logic power_save_sleep_instr,
    input wire logic power_save_idle_instr,
    input wire logic watchdog_clear_instr,
    input wire logic cpu_sleeping,
    input wire logic cpu_idling,
    input wire logic watchdog_timeout,
    input wire logic trap_request,
    input wire logic [3:0] trap_request_priority,
    input wire logic trap_active,
    input wire logic [3:0] trap_active_priority,
    input wire logic [15:0] pin_select_live,
    input wire logic [15:0] pin_select_shadow,
    input wire logic instr_execute,
    input wire logic [7:0] instr_upper_byte,
    input wire logic w_write,
    input wire logic [3:0] w_write_index,
    input wire logic w_pointer_use,
    input wire logic [3:0] w_pointer_index,
    input wire logic branch_reload,
    input wire logic vector_reload,
    input wire logic [23:0] reload_target,
    // Register port
    input wire logic [3:0] addr,
    input wire logic [15:0] wdata,
    input wire logic wr_stb,
    input wire logic rd_stb,
    output logic [15:0] rdata,
    // Reset and status outputs
    output logic system_reset_n,
    output logic cold_reset,
    output logic working_regs_clear,
    output logic wake_request,
    output logic irq
);

    // ==================================================================
    // Input synchronisers
    logic [2:0] sync1_reg;
    logic [2:0] sync2_reg;
    logic por_ok;
    logic bor_ok;
    logic pin_n;

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            sync1_reg <= 3'h0;
            sync2_reg <= 3'h0;
        end else begin
            sync1_reg <= {external_reset_pin_n, supply_above_brownout_threshold, supply_above_poweron_threshold};
            sync2_reg <= sync1_reg;
        end
    end

    assign por_ok = sync2_reg[0];
    assign bor_ok = sync2_reg[1];
    assign pin_n = sync2_reg[2];

    // ==================================================================
    // Power sequencing
    reset_pkg::power_state_t state_reg;
    logic [31:0] cnt_reg;
    logic [2:0] powerup_delay_select_reg;
    logic [31:0] bor_target;
    logic por_event;
    logic bor_event;
    logic power_hold;

    // Brown-out extension plus the selected power-up delay
    assign bor_target = 32'(reset_pkg::BOR_EXT_CYC)
        + 32'(MS_CYCLES) * 32'(reset_pkg::powerup_ms(powerup_delay_select_reg));
    assign por_event = !por_ok && (state_reg != reset_pkg::PW_POR_LOW);
    assign bor_event = por_ok && !bor_ok
        && (state_reg == reset_pkg::PW_BOR_EXT || state_reg == reset_pkg::PW_RUN);
    assign power_hold = (state_reg != reset_pkg::PW_RUN);

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            state_reg <= reset_pkg::PW_POR_LOW;
            cnt_reg <= 32'h0;
        end else if (!por_ok) begin
            state_reg <= reset_pkg::PW_POR_LOW;
            cnt_reg <= 32'h0;
        end else begin
            unique case (state_reg)
                reset_pkg::PW_POR_LOW: begin
                    state_reg <= reset_pkg::PW_POR_EXT;
                    cnt_reg <= 32'h0;
                end
                reset_pkg::PW_POR_EXT: begin
                    if (cnt_reg + 32'h1 >= 32'(reset_pkg::POR_EXT_CYC)) begin
                        state_reg <= bor_ok ? reset_pkg::PW_BOR_EXT : reset_pkg::PW_BOR_LOW;
                        cnt_reg <= 32'h0;
                    end else begin
                        cnt_reg <= cnt_reg + 32'h1;
                    end
                end
                reset_pkg::PW_BOR_LOW: begin
                    if (bor_ok) begin
                        state_reg <= reset_pkg::PW_BOR_EXT;
                    end
                    cnt_reg <= 32'h0;
                end
                reset_pkg::PW_BOR_EXT: begin
                    if (!bor_ok) begin
                        state_reg <= reset_pkg::PW_BOR_LOW;
                        cnt_reg <= 32'h0;
                    end else if (cnt_reg + 32'h1 >= bor_target) begin
                        state_reg <= reset_pkg::PW_RUN;
                        cnt_reg <= 32'h0;
                    end else begin
                        cnt_reg <= cnt_reg + 32'h1;
                    end
                end
                reset_pkg::PW_RUN: begin
                    if (!bor_ok) begin
                        state_reg <= reset_pkg::PW_BOR_LOW;
                    end
                    cnt_reg <= 32'h0;
                end
            endcase
        end
    end

    // ==================================================================
    // External pin filter
    logic [15:0] pin_cnt_reg;
    logic pin_reset_reg;
    logic pin_trip;

    // Short low glitches never reach the counter's end
    assign pin_trip = !pin_n && !pin_reset_reg && (pin_cnt_reg + 16'h1 >= 16'(reset_pkg::PIN_MIN_CYC));

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            pin_cnt_reg <= 16'h0;
            pin_reset_reg <= 1'b0;
        end else if (pin_n) begin
            pin_cnt_reg <= 16'h0;
            pin_reset_reg <= 1'b0;
        end else if (pin_trip) begin
            pin_reset_reg <= 1'b1;
        end else if (!pin_reset_reg) begin
            pin_cnt_reg <= pin_cnt_reg + 16'h1;
        end
    end

    // ==================================================================
    // Warm reset sources
    logic [14:0] w_init_reg;
    logic wdt_reset;
    logic trap_conflict;
    logic mismatch;
    logic illegal_opcode;
    logic uninit_pointer;
    logic security;
    logic illegal_any;
    logic warm_event;
    logic event_reset_reg;
    logic sys_assert;

    // A timeout while asleep or idle only wakes the core
    assign wdt_reset = watchdog_timeout && !(cpu_sleeping || cpu_idling);
    assign trap_conflict = trap_request && trap_active
        && trap_request_priority >= reset_pkg::HARD_TRAP_LO
        && trap_request_priority <= reset_pkg::HARD_TRAP_HI
        && trap_request_priority < trap_active_priority;
    assign mismatch = (pin_select_live != pin_select_shadow);
    assign illegal_opcode = instr_execute && (instr_upper_byte == reset_pkg::ILLEGAL_UPPER);
    assign uninit_pointer = w_pointer_use && (w_pointer_index != reset_pkg::W_STACK)
        && !w_init_reg[w_pointer_index[3:0] == reset_pkg::W_STACK ? 4'h0 : w_pointer_index];
    assign security = (branch_reload || vector_reload)
        && reload_target >= RESTRICT_LO && reload_target <= RESTRICT_HI;
    assign illegal_any = illegal_opcode || uninit_pointer || security;
    assign warm_event = reset_instr || wdt_reset || trap_conflict || mismatch || illegal_any;
    assign sys_assert = power_hold || pin_reset_reg || event_reset_reg;

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            event_reset_reg <= 1'b0;
        end else begin
            // Held one cycle so an instruction reset releases at the next cycle
            event_reset_reg <= warm_event;
        end
    end

    // Working registers count as uninitialised during any reset
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            w_init_reg <= 15'h0;
        end else if (sys_assert) begin
            w_init_reg <= 15'h0;
        end else if (w_write && w_write_index != reset_pkg::W_STACK) begin
            w_init_reg[w_write_index] <= 1'b1;
        end
    end

    // ==================================================================
    // Cause flags
    logic [15:0] cause_reg;
    logic [15:0] cause_next;
    logic [15:0] set_vec;
    logic cause_wr;

    assign cause_wr = wr_stb && (addr == reset_pkg::OFS_CAUSE);

    always_comb begin
        set_vec = 16'h0;
        set_vec[reset_pkg::BIT_PIN] = pin_trip;
        set_vec[reset_pkg::BIT_INSTR] = reset_instr;
        set_vec[reset_pkg::BIT_WDT] = wdt_reset;
        set_vec[reset_pkg::BIT_TRAP] = trap_conflict;
        set_vec[reset_pkg::BIT_MISMATCH] = mismatch;
        set_vec[reset_pkg::BIT_ILLEGAL] = illegal_any;
        set_vec[reset_pkg::BIT_SLEEP] = power_save_sleep_instr;
        set_vec[reset_pkg::BIT_IDLE] = power_save_idle_instr;
        set_vec[reset_pkg::BIT_BOR] = por_event || bor_event;
        set_vec[reset_pkg::BIT_POR] = por_event;
    end

    always_comb begin
        cause_next = cause_reg;
        if (cause_wr) begin
            cause_next = wdata & reset_pkg::FLAG_MASK;
        end
        if (power_save_sleep_instr || power_save_idle_instr || watchdog_clear_instr) begin
            cause_next[reset_pkg::BIT_WDT] = 1'b0;
        end
        if (por_event) begin
            cause_next = cause_next & reset_pkg::POR_KEEP;
        end else if (bor_event) begin
            cause_next = cause_next & reset_pkg::BOR_KEEP;
        end
        // Hardware sets win over any clear in the same cycle
        cause_next = cause_next | set_vec;
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            cause_reg <= reset_pkg::CAUSE_RESET;
        end else begin
            cause_reg <= cause_next;
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            powerup_delay_select_reg <= reset_pkg::PDS_RESET;
        end else if (wr_stb && addr == reset_pkg::OFS_POWER_CONFIG) begin
            powerup_delay_select_reg <= wdata[reset_pkg::PDS_W-1:0];
        end
    end

    // ==================================================================
    // Interrupt status, clear and enable
    logic [15:0] irq_status_reg;
    logic [15:0] irq_enable_reg;
    logic [15:0] irq_clear;

    assign irq_clear = (wr_stb && addr == reset_pkg::OFS_IRQ_CLEAR) ? wdata : 16'h0;

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            irq_status_reg <= 16'h0;
            irq_enable_reg <= 16'h0;
            irq <= 1'b0;
        end else begin
            irq_status_reg <= (irq_status_reg & ~irq_clear) | set_vec;
            if (wr_stb && addr == reset_pkg::OFS_IRQ_ENABLE) begin
                irq_enable_reg <= wdata & reset_pkg::FLAG_MASK;
            end
            irq <= |(irq_status_reg & irq_enable_reg);
        end
    end

    // ==================================================================
    // Read port
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            rdata <= 16'h0;
        end else if (rd_stb) begin
            unique case (addr)
                reset_pkg::OFS_CAUSE: rdata <= cause_reg;
                reset_pkg::OFS_IRQ_STATUS: rdata <= irq_status_reg;
                reset_pkg::OFS_IRQ_ENABLE: rdata <= irq_enable_reg;
                reset_pkg::OFS_POWER_CONFIG: rdata <= {13'h0, powerup_delay_select_reg};
                default: rdata <= 16'h0;
            endcase
        end else begin
            rdata <= 16'h0;
        end
    end

    // ==================================================================
    // Reset outputs
    // Synchronous here: the watchdog request is registered, costing one cycle
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            system_reset_n <= 1'b0;
            cold_reset <= 1'b1;
            working_regs_clear <= 1'b1;
            wake_request <= 1'b0;
        end else begin
            system_reset_n <= !sys_assert;
            cold_reset <= power_hold;
            working_regs_clear <= sys_assert;
            wake_request <= watchdog_timeout && (cpu_sleeping || cpu_idling);
        end
    end

endmodule : system_reset_cause_logic

// ---- verification/system_reset_cause_logic_properties.sv ----
// ========
// Reset source checks
module reset_cause_checker #(
    parameter logic [23:0] RESTRICT_LO = 24'h000200,
    parameter logic [23:0] RESTRICT_HI = 24'h0003ff
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rstn,
    // Sources
    input wire logic supply_above_brownout_threshold,
    input wire logic external_reset_pin_n,
    input wire logic reset_instr,
    input wire logic cpu_sleeping,
    input wire logic cpu_idling,
    input wire logic watchdog_timeout,
    input wire logic trap_request,
    input wire logic [3:0] trap_request_priority,
    input wire logic trap_active,
    input wire logic [3:0] trap_active_priority,
    input wire logic [15:0] pin_select_live,
    input wire logic [15:0] pin_select_shadow,
    input wire logic instr_execute,
    input wire logic [7:0] instr_upper_byte,
    input wire logic branch_reload,
    input wire logic vector_reload,
    input wire logic [23:0] reload_target,
    // Outputs
    input wire logic system_reset_n,
    input wire logic cold_reset,
    input wire logic working_regs_clear,
    input wire logic wake_request
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rstn);

    // An event only starts a fresh reset while the part runs
    wire logic warm = system_reset_n && !cold_reset;
    wire logic sleepy = cpu_sleeping || cpu_idling;
    wire logic hard = trap_request_priority >= 4'hd && trap_request_priority < trap_active_priority;
    wire logic conflict = trap_request && trap_active && hard;
    wire logic in_win = reload_target >= RESTRICT_LO && reload_target <= RESTRICT_HI;

    chk_instr_reset: assert property (reset_instr && warm |-> ##[2:3] !system_reset_n)
        else $error("instr reset missing");
    chk_warm_release: assert property ($fell(system_reset_n) && !cold_reset && external_reset_pin_n
        && supply_above_brownout_threshold && pin_select_live == pin_select_shadow |-> ##[1:2] system_reset_n)
        else $error("warm reset stuck");
    chk_wdt_reset: assert property (watchdog_timeout && !sleepy && warm |-> ##[2:3] !system_reset_n)
        else $error("watchdog reset missing");
    chk_sleep_wake: assert property (watchdog_timeout && sleepy |-> ##[1:2] wake_request)
        else $error("wake missing");
    chk_sleep_no_reset: assert property (watchdog_timeout && sleepy && warm |=> system_reset_n [*3])
        else $error("reset while asleep");
    chk_trap_conflict: assert property (conflict && warm |-> ##[2:3] !system_reset_n)
        else $error("trap reset missing");
    chk_shadow_diff: assert property (pin_select_live != pin_select_shadow && warm |-> ##[2:3] !system_reset_n)
        else $error("mismatch reset missing");
    chk_illegal_op: assert property (instr_execute && instr_upper_byte == 8'h3f && warm |-> ##[2:3] !system_reset_n)
        else $error("opcode reset missing");
    chk_secure_reload: assert property ((branch_reload || vector_reload) && in_win && warm |-> ##[2:3] !system_reset_n)
        else $error("security reset missing");
    chk_brownout_hold: assert property (!supply_above_brownout_threshold [*6] |-> cold_reset && !system_reset_n)
        else $error("brownout not held");
    chk_regs_clear: assert property (!system_reset_n |-> working_regs_clear)
        else $error("working regs not cleared");
endmodule : reset_cause_checker

bind system_reset_cause_logic reset_cause_checker #(
    .RESTRICT_LO(RESTRICT_LO),
    .RESTRICT_HI(RESTRICT_HI)
) reset_cause_checker_i (.*);

// ---- verification/core_model.sv ----
// ========
// Core, watchdog and supply side
module core_model (
    // Clock
    input wire logic core_clk,
    // Supplies and pin
    output logic supply_above_poweron_threshold,
    output logic supply_above_brownout_threshold,
    output logic external_reset_pin_n,
    // Core events
    output logic reset_instr,
    output logic power_save_sleep_instr,
    output logic power_save_idle_instr,
    output logic watchdog_clear_instr,
    output logic cpu_sleeping,
    output logic cpu_idling,
    output logic watchdog_timeout,
    output logic trap_request,
    output logic [3:0] trap_request_priority,
    output logic trap_active,
    output logic [3:0] trap_active_priority,
    output logic [15:0] pin_select_live,
    output logic [15:0] pin_select_shadow,
    output logic instr_execute,
    output logic [7:0] instr_upper_byte,
    output logic w_write,
    output logic [3:0] w_write_index,
    output logic w_pointer_use,
    output logic [3:0] w_pointer_index,
    output logic branch_reload,
    output logic vector_reload,
    output logic [23:0] reload_target
);
    timeunit 1ns;
    timeprecision 1ns;

    task automatic idle();
        {reset_instr, power_save_sleep_instr, power_save_idle_instr, watchdog_clear_instr} <= '0;
        {cpu_sleeping, cpu_idling, watchdog_timeout, trap_request, instr_execute} <= '0;
        {w_pointer_use, branch_reload, vector_reload} <= '0;
        pin_select_live <= pin_select_shadow;
        external_reset_pin_n <= 1'b1;
        {supply_above_poweron_threshold, supply_above_brownout_threshold} <= 2'b11;
    endtask : idle

    // A priority-15 trap stays in service so hard requests at 13 or 14 conflict
    initial begin
        {trap_active, trap_active_priority, pin_select_shadow} = {1'b1, 4'hf, 16'h5a3c};
        {trap_request_priority, w_pointer_index, instr_upper_byte, reload_target} = '0;
        {w_write, w_write_index} = '0;
        idle();
    end

    // For kinds 0-6 and 10, good gives a real event, otherwise a near miss
    task automatic fire(input int k, input logic good);
        logic [7:0] r;
        r = 8'($urandom);
        @(posedge core_clk);
        case (k)
            0: reset_instr <= good;
            1: watchdog_timeout <= good;
            2: begin
                trap_request <= 1'b1;
                trap_request_priority <= good ? 4'hd + 4'(r[0]) : 4'(r % 8'd13);
            end
            3: pin_select_live <= good ? ~pin_select_shadow : pin_select_shadow;
            4: begin
                instr_execute <= 1'b1;
                instr_upper_byte <= good ? 8'h3f : (r == 8'h3f ? 8'h3e : r);
            end
            5: begin
                w_pointer_use <= 1'b1;
                w_pointer_index <= good ? 4'(r % 8'd15) : 4'hf;
            end
            6: begin
                {branch_reload, vector_reload} <= {r[0], !r[0]};
                reload_target <= good ? 24'h000200 + 24'(r) : 24'h000400 + 24'(r);
            end
            7: {watchdog_timeout, cpu_sleeping, cpu_idling} <= {1'b1, r[0], !r[0]};
            8: watchdog_clear_instr <= 1'b1;
            9: {power_save_sleep_instr, power_save_idle_instr} <= {good, !good};
            default: external_reset_pin_n <= 1'b0;
        endcase
        repeat (k == 10 ? (good ? 25 : 15) : 1) @(posedge core_clk);
        idle();
    endtask : fire

    task automatic dip(input logic on, input int n);
        @(posedge core_clk);
        {supply_above_poweron_threshold, supply_above_brownout_threshold} <= {!on, 1'b0};
        repeat (n) @(posedge core_clk);
        idle();
    endtask : dip
endmodule : core_model

// ---- verification/tb.sv ----
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int MSC = 2;
    logic core_clk = 1'b0;
    logic rstn, wr_stb, rd_stb, system_reset_n, cold_reset, working_regs_clear, wake_request, irq;
    logic [3:0] addr, trap_request_priority, trap_active_priority, w_write_index, w_pointer_index;
    logic [15:0] wdata, rdata, pin_select_live, pin_select_shadow, d;
    logic supply_above_poweron_threshold, supply_above_brownout_threshold, external_reset_pin_n;
    logic reset_instr, power_save_sleep_instr, power_save_idle_instr, watchdog_clear_instr, cpu_sleeping;
    logic cpu_idling, watchdog_timeout, trap_request, trap_active, instr_execute, w_write, w_pointer_use;
    logic branch_reload, vector_reload;
    logic [7:0] instr_upper_byte;
    logic [23:0] reload_target;
    int mismatches = 0;
    int num_checks = 0;
    int cycles = 0;
    int n;

    always #50 core_clk = ~core_clk;

    system_reset_cause_logic #(.MS_CYCLES(MSC)) system_reset_cause_logic_i (.*);
    core_model core_model_i (.*);

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic finish_test();
        $display("checks=%0d mismatches=%0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : finish_test

    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (cycles == 40000) begin
            mismatches++;
            finish_test();
        end
    end

    task automatic wr(input logic [3:0] a, input logic [15:0] v);
        @(posedge core_clk);
        {addr, wdata, wr_stb} <= {a, v, 1'b1};
        @(posedge core_clk);
        wr_stb <= 1'b0;
    endtask : wr

    task automatic rd(input logic [3:0] a);
        @(posedge core_clk);
        {addr, rd_stb} <= {a, 1'b1};
        @(posedge core_clk);
        rd_stb <= 1'b0;
        @(posedge core_clk);
        d = rdata;
    endtask : rd

    task automatic wait_run();
        n = 0;
        while (system_reset_n !== 1'b1 && n < 20000) begin
            @(posedge core_clk);
            n++;
        end
    endtask : wait_run

    function automatic logic [15:0] exp_cause(input int k, input logic g);
        logic [15:0] t[11];
        t = '{16'h0040, 16'h0010, 16'h8000, 16'h0200, 16'h4000, 16'h4000, 16'h4000, 16'h0, 16'h0, 16'h0008, 16'h0080};
        if (k == 9 && !g) return 16'h0004;
        return (g || k inside {7, 8}) ? t[k] : 16'h0000;
    endfunction : exp_cause

    function automatic int exp_delay(input int s);
        return 1000 + MSC * (s == 0 ? 0 : 1 << s);
    endfunction : exp_delay

    initial begin
        logic g;
        rstn = 1'b0;
        {wr_stb, rd_stb, addr, wdata} = '0;
        n = $urandom(12);
        repeat (10) @(posedge core_clk);
        rstn <= 1'b1;
        wait_run();
        rd(reset_pkg::OFS_CAUSE);
        check(d, 16'h0003);
        rd(4'h5);
        check(d, 16'h0000);
        wr(reset_pkg::OFS_CAUSE, 16'hffff);
        rd(reset_pkg::OFS_CAUSE);
        check(d, 16'hc2df);
        check(16'(system_reset_n), 16'h0001);
        $display("end of startup");
        for (int r = 0; r < 3; r++) begin
            for (int k = 0; k < 11; k++) begin
                g = (r == 2) ? 1'($urandom) : (r == 0);
                wr(reset_pkg::OFS_CAUSE, k inside {8, 9} ? 16'h0010 : 16'h0000);
                core_model_i.fire(k, g);
                repeat (8) @(posedge core_clk);
                rd(reset_pkg::OFS_CAUSE);
                check(d, exp_cause(k, g));
            end
        end
        $display("end of events");
        wr(reset_pkg::OFS_IRQ_CLEAR, 16'hffff);
        wr(reset_pkg::OFS_IRQ_ENABLE, 16'h0040);
        core_model_i.fire(0, 1'b1);
        repeat (8) @(posedge core_clk);
        check(16'(irq), 16'h0001);
        rd(reset_pkg::OFS_IRQ_STATUS);
        check(d, 16'h0040);
        wr(reset_pkg::OFS_IRQ_CLEAR, 16'h0040);
        wr(reset_pkg::OFS_IRQ_ENABLE, 16'h0010);
        core_model_i.fire(0, 1'b1);
        repeat (8) @(posedge core_clk);
        check(16'(irq), 16'h0000);
        rd(reset_pkg::OFS_IRQ_CLEAR);
        check(d, 16'h0000);
        $display("end of interrupt");
        wr(reset_pkg::OFS_CAUSE, 16'h00c0);
        for (int s = 7; s >= 0; s--) begin
            wr(reset_pkg::OFS_POWER_CONFIG, 16'(s));
            core_model_i.dip(1'b0, 8);
            check(16'(cold_reset), 16'h0001);
            wait_run();
            check(16'(n >= exp_delay(s) && n <= exp_delay(s) + 8), 16'h0001);
        end
        rd(reset_pkg::OFS_CAUSE);
        check(d, 16'h0082);
        core_model_i.dip(1'b0, 8);
        repeat (500) @(posedge core_clk);
        core_model_i.dip(1'b0, 8);
        wait_run();
        check(16'(n >= 1000 && n <= 1008), 16'h0001);
        wr(reset_pkg::OFS_CAUSE, 16'hffff);
        core_model_i.dip(1'b1, 8);
        wait_run();
        rd(reset_pkg::OFS_CAUSE);
        check(d, 16'h4003);
        $display("end of power");
        finish_test();
    end
endmodule : tb
